//--- hdl/quad_pot_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "quad_pot_defines.svh"
// Operation
// - Ack address only when straps match
// - Stop after NV command starts write, inputs ignored
// - No address ack while NV write busy
// - Instruction byte: opcode, register, pot fields
// - Opcode 1001 reads wiper register
// - Opcode 1010 writes wiper register
// - Opcode 1011 reads stored setting
// - Opcode 1100 writes stored setting, nonvolatile
// - Opcode 1101 copies setting into wiper
// - Opcode 1110 saves wiper into setting
// - Opcode 0001 global setting to wipers
// - Opcode 1000 global wipers to settings
// - Opcode 0010 arms step mode
// - Transfers finish after instruction byte, stop
// - Tap output follows transfer after settle delay
// - Wiper save busy for full write time
// - Register reads and writes use three bytes
// - Clock high with data steps wiper
// - Six-bit counter decoded to one tap
// - Reset loads wiper from setting zero
// - Stored setting writes finish within 10ms
// - Write-protect low blocks nonvolatile writes
// - Upper address bits match device type
// - Ack address, instruction and data byte
module quad_pot_command_decoder
   import quad_pot_pkg::*;
#(
   parameter logic [3:0] DEV_TYPE = 4'hA, // Arbitrary value
   parameter int NV_WRITE_CYCLES = `NV_WRITE_TIME_US * `SYS_CLK_MHZ,
   parameter int WIPER_SETTLE_NS = 1000
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   input wire logic [3:0] i_addr_sel,
   input wire logic i_write_protect_n,
   output logic [23:0] o_wiper_pos,
   output logic [255:0] o_wiper_tap,
   output logic o_nv_busy
);
   localparam int BW = $clog2(NV_WRITE_CYCLES + 1);
   localparam int SETTLE_CYCLES = (WIPER_SETTLE_NS * `SYS_CLK_MHZ + 999) / 1000;

   logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
   logic [3:0] addr_s1_r, addr_s2_r;
   logic wp_s1_r, wp_s2_r;
   logic scl_rise, scl_fall, start_cond, stop_cond;
   link_state_t st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt, instr_r, instr_nxt, data_r, data_nxt;
   logic armed_r, armed_nxt, oe_n_r, oe_n_nxt;
   logic [3:0][5:0] wiper_r, wiper_nxt;
   // Settings array is nonvolatile: contents never cleared by reset
   logic [15:0][5:0] nv_r = {16{`NV_ERASED}};
   logic [15:0][5:0] nv_nxt;
   logic [3:0][63:0] onehot_r, onehot_nxt;
   logic [BW-1:0] busy_r, busy_nxt, settle_r, settle_nxt;
   logic busy;
   logic [3:0] op;
   logic [1:0] rs, ps;
   logic rx_valid;

   // Pins are asynchronous to i_clk_sys; third stage only feeds edge logic
   always_ff @(posedge i_clk_sys) begin
      scl_s1_r <= i_scl;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= i_sda;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      addr_s1_r <= i_addr_sel;
      addr_s2_r <= addr_s1_r;
      wp_s1_r <= i_write_protect_n;
      wp_s2_r <= wp_s1_r;
   end

   assign scl_rise = scl_s2_r & ~scl_d_r;
   assign scl_fall = ~scl_s2_r & scl_d_r;
   assign start_cond = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   assign stop_cond = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
   assign busy = (busy_r != '0);
   assign op = instr_r[`F_OPC];
   assign rs = instr_r[`F_RSEL];
   assign ps = instr_r[`F_PSEL];

   // Legal opcode and field combinations
   always_comb begin
      case (sh_r[`F_OPC])
         `OP_RD_WIPER, `OP_WR_WIPER, `OP_STEP: rx_valid = (sh_r[`F_RSEL] == `SEL_ZERO);
         `OP_RD_SETTING, `OP_WR_SETTING, `OP_LOAD_WIPER, `OP_SAVE_WIPER: rx_valid = 1'b1;
         `OP_LOAD_ALL, `OP_SAVE_ALL: rx_valid = (sh_r[`F_PSEL] == `SEL_ZERO);
         default: rx_valid = 1'b0;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      instr_nxt = instr_r;
      data_nxt = data_r;
      armed_nxt = armed_r;
      oe_n_nxt = oe_n_r;
      wiper_nxt = wiper_r;
      nv_nxt = nv_r;
      busy_nxt = busy ? busy_r - 1'b1 : busy_r;
      settle_nxt = (settle_r != '0) ? settle_r - 1'b1 : settle_r;
      onehot_nxt = onehot_r;
      if (busy) begin
         // Bus is deaf during the write, so polls go unanswered
         st_nxt = ST_IDLE;
         oe_n_nxt = 1'b1;
         armed_nxt = 1'b0;
      end else if (start_cond) begin
         st_nxt = ST_ADDR;
         cnt_nxt = '0;
         oe_n_nxt = 1'b1;
         armed_nxt = 1'b0;
      end else if (stop_cond) begin
         st_nxt = ST_IDLE;
         oe_n_nxt = 1'b1;
         armed_nxt = 1'b0;
         if (armed_r) begin
            case (op)
               `OP_WR_WIPER: wiper_nxt[ps] = data_r[5:0];
               `OP_WR_SETTING: if (wp_s2_r) begin
                  nv_nxt[{ps, rs}] = data_r[5:0];
                  busy_nxt = BW'(NV_WRITE_CYCLES);
               end
               `OP_LOAD_WIPER: begin
                  wiper_nxt[ps] = nv_r[{ps, rs}];
                  settle_nxt = BW'(SETTLE_CYCLES);
               end
               `OP_SAVE_WIPER: if (wp_s2_r) begin
                  nv_nxt[{ps, rs}] = wiper_r[ps];
                  busy_nxt = BW'(NV_WRITE_CYCLES);
               end
               `OP_LOAD_ALL: begin
                  for (int k = 0; k < 4; k++) wiper_nxt[k] = nv_r[{2'(k), rs}];
                  settle_nxt = BW'(SETTLE_CYCLES);
               end
               `OP_SAVE_ALL: if (wp_s2_r) begin
                  for (int k = 0; k < 4; k++) nv_nxt[{2'(k), rs}] = wiper_r[k];
                  busy_nxt = BW'(NV_WRITE_CYCLES);
               end
               default: ;
            endcase
         end
      end else begin
         case (st_r)
            ST_ADDR, ST_INSTR, ST_DATA_RX: begin
               if (scl_rise) begin
                  sh_nxt = {sh_r[6:0], sda_s2_r};
                  cnt_nxt = cnt_r + 1'b1;
               end
               if (scl_fall && cnt_r == `BYTE_BITS) begin
                  cnt_nxt = '0;
                  st_nxt = ST_IDLE;
                  if (st_r == ST_ADDR) begin
                     if (sh_r[`F_DEVTYPE] == DEV_TYPE && sh_r[`F_DEVADDR] == addr_s2_r) begin
                        oe_n_nxt = 1'b0;
                        st_nxt = ST_ADDR_ACK;
                     end
                  end else if (st_r == ST_INSTR) begin
                     if (rx_valid) begin
                        oe_n_nxt = 1'b0;
                        instr_nxt = sh_r;
                        st_nxt = ST_INSTR_ACK;
                     end
                  end else begin
                     oe_n_nxt = 1'b0;
                     data_nxt = sh_r;
                     armed_nxt = 1'b1;
                     st_nxt = ST_DATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: if (scl_fall) begin
               oe_n_nxt = 1'b1;
               st_nxt = ST_INSTR;
            end
            ST_INSTR_ACK: if (scl_fall) begin
               oe_n_nxt = 1'b1;
               cnt_nxt = '0;
               case (op)
                  `OP_RD_WIPER, `OP_RD_SETTING: begin
                     // Upper two bits of a read byte are zero
                     sh_nxt = {2'b00, (op == `OP_RD_WIPER) ? wiper_r[ps]
                                                          : nv_r[{ps, rs}]};
                     oe_n_nxt = 1'b0;
                     st_nxt = ST_DATA_TX;
                  end
                  `OP_WR_WIPER, `OP_WR_SETTING: st_nxt = ST_DATA_RX;
                  `OP_STEP: st_nxt = ST_STEP;
                  default: begin
                     armed_nxt = 1'b1;
                     st_nxt = ST_WAIT;
                  end
               endcase
            end
            ST_DATA_ACK: if (scl_fall) begin
               oe_n_nxt = 1'b1;
               st_nxt = ST_WAIT;
            end
            ST_DATA_TX: begin
               if (scl_rise) cnt_nxt = cnt_r + 1'b1;
               if (scl_fall) begin
                  if (cnt_r == `BYTE_BITS) begin
                     // Master ack is not checked; only a stop or a new start ends the frame
                     oe_n_nxt = 1'b1;
                     st_nxt = ST_WAIT;
                  end else begin
                     sh_nxt = {sh_r[6:0], 1'b0};
                     oe_n_nxt = sh_r[6];
                  end
               end
            end
            ST_STEP: if (scl_rise) begin
               if (sda_s2_r && wiper_r[ps] != `WIPER_MAX) begin
                  wiper_nxt[ps] = wiper_r[ps] + 1'b1;
               end else if (!sda_s2_r && wiper_r[ps] != `WIPER_MIN) begin
                  wiper_nxt[ps] = wiper_r[ps] - 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (st_r == ST_DATA_TX && !(busy || start_cond || stop_cond) && scl_fall
          && cnt_r != `BYTE_BITS) oe_n_nxt = sh_r[6];
      for (int k = 0; k < 4; k++) begin
         // Switch change waits out a transfer; one tap on at a time
         if (settle_r == '0) onehot_nxt[k] = 64'h1 << wiper_r[k];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      nv_r <= nv_nxt;
      if (i_sys_rst) begin
         st_r <= ST_IDLE;
         cnt_r <= '0;
         sh_r <= '0;
         instr_r <= '0;
         data_r <= '0;
         armed_r <= 1'b0;
         oe_n_r <= 1'b1;
         busy_r <= '0;
         settle_r <= '0;
         for (int k = 0; k < 4; k++) begin
            wiper_r[k] <= nv_r[{2'(k), 2'b00}];
            onehot_r[k] <= 64'h1 << nv_r[{2'(k), 2'b00}];
         end
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         instr_r <= instr_nxt;
         data_r <= data_nxt;
         armed_r <= armed_nxt;
         oe_n_r <= oe_n_nxt;
         busy_r <= busy_nxt;
         settle_r <= settle_nxt;
         wiper_r <= wiper_nxt;
         onehot_r <= onehot_nxt;
      end
   end

   assign o_sda = 1'b0;
   assign o_sda_oe_n = oe_n_r;
   assign o_wiper_pos = wiper_r;
   assign o_wiper_tap = onehot_r;
   assign o_nv_busy = busy;

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   sequence s_byte_end(link_state_t s);
      st_r == s && scl_fall && cnt_r == `BYTE_BITS && !busy && !start_cond && !stop_cond;
   endsequence
   sequence s_nv_commit;
      stop_cond && !busy && armed_r && wp_s2_r
         && (op == `OP_WR_SETTING || op == `OP_SAVE_WIPER || op == `OP_SAVE_ALL);
   endsequence

   AST_ADDR_MISMATCH: assert property (
      s_byte_end(ST_ADDR) ##0 (sh_r[`F_DEVADDR] != addr_s2_r) |=> oe_n_r && st_r == ST_IDLE)
      else $error("ack given on strap mismatch");
   AST_DEVTYPE: assert property (
      s_byte_end(ST_ADDR) ##0 (sh_r[`F_DEVTYPE] != DEV_TYPE) |=> oe_n_r)
      else $error("ack given on wrong device type");
   AST_ADDR_ACK: assert property (
      s_byte_end(ST_ADDR) ##0 (sh_r == {DEV_TYPE, addr_s2_r}) |=> !oe_n_r && st_r == ST_ADDR_ACK)
      else $error("matching address not acked");
   AST_NV_START: assert property (
      s_nv_commit |=> busy_r == BW'(NV_WRITE_CYCLES) && st_r == ST_IDLE)
      else $error("nv write cycle not started");
   AST_BUSY_DEAF: assert property (
      busy |=> oe_n_r && st_r == ST_IDLE)
      else $error("bus answered while busy");
   AST_WP_BLOCK: assert property (
      stop_cond && !busy && !wp_s2_r |=> !busy && $stable(nv_r))
      else $error("write protect ignored");
   AST_STEP_UP: assert property (
      st_r == ST_STEP && scl_rise && sda_s2_r && !busy && !start_cond && !stop_cond
      && wiper_r[ps] != `WIPER_MAX |=> wiper_r[ps] == $past(wiper_r[ps]) + 6'h01)
      else $error("step up failed");
   AST_STEP_SAT: assert property (
      st_r == ST_STEP && scl_rise && !busy && !start_cond && !stop_cond
      && ((sda_s2_r && wiper_r[ps] == `WIPER_MAX) || (!sda_s2_r && wiper_r[ps] == `WIPER_MIN))
      |=> $stable(wiper_r))
      else $error("step wrapped");
   AST_READ_WIPER: assert property (
      st_r == ST_INSTR_ACK && scl_fall && op == `OP_RD_WIPER
      && !busy && !start_cond && !stop_cond
      |=> sh_r == {2'b00, $past(wiper_r[ps])} && st_r == ST_DATA_TX)
      else $error("wrong read data");
   AST_SETTLE: assert property (
      stop_cond && !busy && armed_r && op == `OP_LOAD_WIPER |=> $stable(onehot_r) [*2])
      else $error("wiper moved before settle");
endmodule : quad_pot_command_decoder
`default_nettype wire

//--- hdl/quad_pot_defines.svh
`ifndef QUAD_POT_DEFINES_SVH
`define QUAD_POT_DEFINES_SVH
`define SYS_CLK_MHZ 125
`define NV_WRITE_TIME_US 10000
`define F_OPC 7:4
`define F_RSEL 3:2
`define F_PSEL 1:0
`define F_DEVTYPE 7:4
`define F_DEVADDR 3:0
`define OP_RD_WIPER 4'h9
`define OP_WR_WIPER 4'hA
`define OP_RD_SETTING 4'hB
`define OP_WR_SETTING 4'hC
`define OP_LOAD_WIPER 4'hD
`define OP_SAVE_WIPER 4'hE
`define OP_LOAD_ALL 4'h1
`define OP_SAVE_ALL 4'h8
`define OP_STEP 4'h2
`define SEL_ZERO 2'h0
`define BYTE_BITS 4'h8
`define WIPER_MAX 6'h3F
`define WIPER_MIN 6'h00
`define NV_ERASED 6'h00
`endif

//--- hdl/quad_pot_pkg.sv
package quad_pot_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INSTR, ST_INSTR_ACK,
      ST_DATA_RX, ST_DATA_ACK, ST_DATA_TX, ST_STEP, ST_WAIT
   } link_state_t;
   typedef logic [5:0] tap_t;
endpackage : quad_pot_pkg

//--- tb/two_wire_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
   input wire logic i_clk_sys,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_pull
);
   // Idle bus: clock parked high, data released to the pull-up
   initial begin
      o_scl = 1'b1;
      o_sda_pull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : tick
   // Data moves only in the low phase; sampled late in the high phase
   task automatic bit_io(input logic b, output logic r);
      o_sda_pull = ~b;
      tick(4);
      o_scl = 1'b1;
      tick(3);
      r = i_sda;
      tick(1);
      o_scl = 1'b0;
   endtask : bit_io
   task automatic start();
      o_sda_pull = 1'b0;
      tick(4);
      o_scl = 1'b1;
      tick(4);
      o_sda_pull = 1'b1;
      tick(4);
      o_scl = 1'b0;
   endtask : start
   task automatic stop();
      o_sda_pull = 1'b1;
      tick(4);
      o_scl = 1'b1;
      tick(4);
      o_sda_pull = 1'b0;
      tick(4);
   endtask : stop
   // MSB first, ninth clock reads the acknowledge
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : put_byte
   // Ends with no-acknowledge, which the device ignores
   task automatic get_byte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(1'b1, r);
   endtask : get_byte
endmodule : two_wire_master_model
`default_nettype wire

//--- tb/test_quad_pot_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "quad_pot_defines.svh"
module test_quad_pot_command_decoder;
   localparam logic [7:0] ADR = 8'h69; // Type nibble arbitrary
   logic clk, rst, scl, pull, oe_n, sda_o, wp_n, busy, sda;
   logic [3:0] straps;
   logic [23:0] pos;
   logic [255:0] tap;
   logic [2:0] a;
   logic [7:0] r;
   int n;
   int err_total = 0;
   int checks_done = 0;
   // Open-drain wire with pull-up
   assign sda = ~pull & (oe_n | sda_o);
   quad_pot_command_decoder #(.DEV_TYPE(4'h6), .NV_WRITE_CYCLES(200), .WIPER_SETTLE_NS(40)) dut (
      .i_clk_sys(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda(sda_o),
      .o_sda_oe_n(oe_n), .i_addr_sel(straps), .i_write_protect_n(wp_n),
      .o_wiper_pos(pos), .o_wiper_tap(tap), .o_nv_busy(busy));
   two_wire_master_model bus (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic results();
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk
   // Mode 0 address only, 1 two bytes, 2 write data, 3 read data
   task automatic frame(input logic [7:0] adr, input logic [7:0] ins, input int mode,
                        input logic [7:0] d);
      a = 3'h0;
      r = 8'h00;
      bus.start();
      bus.put_byte(adr, a[0]);
      if (a[0] && mode > 0) bus.put_byte(ins, a[1]);
      if (a[1] && mode == 2) bus.put_byte(d, a[2]);
      if (a[1] && mode == 3) bus.get_byte(r);
      bus.stop();
   endtask : frame
   task automatic poll();
      n = 0;
      a = 3'h0;
      while (!a[0] && n < 10) begin
         frame(ADR, 8'h00, 0, 8'h00);
         n++;
      end
      if (!a[0]) begin
         err_total++;
         $display("MISMATCH %0t poll timeout", $time);
         results();
      end
   endtask : poll
   // Checked before stop, whose rising clock would count as one more step
   task automatic step(input logic [1:0] p, input logic [7:0] pat, input int k,
                       input logic [5:0] exp);
      logic b;
      bus.start();
      bus.put_byte(ADR, b);
      bus.put_byte({`OP_STEP, 2'h0, p}, b);
      for (int i = 0; i < k; i++) bus.bit_io(pat[i], b);
      bus.tick(4);
      chk(pos[6*p +: 6], exp, "step");
      bus.stop();
   endtask : step
   initial begin
      rst = 1'b1;
      straps = 4'h9;
      wp_n = 1'b1;
      bus.tick(10);
      rst = 1'b0;
      bus.tick(3);
      chk(pos, 24'h0, "recall");
      chk(tap[63:0], 64'h1, "tap0");
      frame(ADR, {`OP_WR_WIPER, 2'h0, 2'h2}, 2, 8'hEA);
      chk(a, 3'h7, "acks");
      bus.tick(2);
      chk(pos[17:12], 6'h2A, "wr wiper");
      frame(ADR, {`OP_RD_WIPER, 2'h0, 2'h2}, 3, 8'h00);
      chk(r, 8'h2A, "rd wiper");
      frame({ADR[7:4], 4'h8}, 8'h00, 1, 8'h00);
      chk(a, 3'h0, "straps");
      frame({4'h7, ADR[3:0]}, 8'h00, 1, 8'h00);
      chk(a, 3'h0, "type");
      frame(ADR, 8'h94, 1, 8'h00);
      chk(a, 3'h1, "bad op");
      frame(ADR, {`OP_WR_SETTING, 2'h1, 2'h1}, 2, 8'h15);
      chk(busy, 1'b1, "busy");
      frame(ADR, 8'h00, 0, 8'h00);
      chk(a, 3'h0, "busy poll");
      poll();
      frame(ADR, {`OP_RD_SETTING, 2'h1, 2'h1}, 3, 8'h00);
      chk(r, 8'h15, "rd setting");
      frame(ADR, {`OP_LOAD_WIPER, 2'h1, 2'h1}, 1, 8'h00);
      chk(a, 3'h3, "load acks");
      bus.tick(2);
      chk(pos[11:6], 6'h15, "load");
      n = 0;
      while (tap[85] !== 1'b1 && n < 40) begin
         bus.tick(1);
         n++;
      end
      chk(tap[127:64], 64'h1 << 21, "tap1");
      wp_n = 1'b0;
      frame(ADR, {`OP_WR_SETTING, 2'h1, 2'h1}, 2, 8'h0B);
      bus.tick(2);
      chk(busy, 1'b0, "wp busy");
      wp_n = 1'b1;
      frame(ADR, {`OP_RD_SETTING, 2'h1, 2'h1}, 3, 8'h00);
      chk(r, 8'h15, "wp keep");
      frame(ADR, {`OP_SAVE_WIPER, 2'h3, 2'h2}, 1, 8'h00);
      chk(busy, 1'b1, "save busy");
      poll();
      frame(ADR, {`OP_RD_SETTING, 2'h3, 2'h2}, 3, 8'h00);
      chk(r, 8'h2A, "save");
      frame(ADR, {`OP_LOAD_ALL, 2'h3, 2'h0}, 1, 8'h00);
      bus.tick(2);
      chk(pos, 24'h02A000, "load all");
      frame(ADR, {`OP_WR_WIPER, 2'h0, 2'h3}, 2, 8'h3E);
      frame(ADR, {`OP_SAVE_ALL, 2'h2, 2'h0}, 1, 8'h00);
      poll();
      frame(ADR, {`OP_RD_SETTING, 2'h2, 2'h3}, 3, 8'h00);
      chk(r, 8'h3E, "gsave");
      step(2'h0, 8'h1C, 5, 6'h03);
      step(2'h3, 8'h07, 3, 6'h3F);
      // Power-on value of pot 1, then a reset in mid-run with new straps
      frame(ADR, {`OP_WR_SETTING, 2'h0, 2'h1}, 2, 8'h2D);
      poll();
      rst = 1'b1;
      straps = 4'h6;
      bus.tick(3);
      rst = 1'b0;
      bus.tick(3);
      chk(pos, 24'h000B40, "re-recall");
      chk(tap[127:64], 64'h1 << 45, "re-tap");
      frame({ADR[7:4], 4'h6}, {`OP_RD_WIPER, 2'h0, 2'h1}, 3, 8'h00);
      chk(r, 8'h2D, "new straps");
      frame(ADR, 8'h00, 0, 8'h00);
      chk(a, 3'h0, "old straps");
      results();
   end
endmodule : test_quad_pot_command_decoder
`default_nettype wire
